// ### core/ucs_clock_reset_startup.sv
`timescale 1ns/1ps
module ucs_clock_reset_startup #(
   parameter int unsigned LOCK_EDGES = ucs_pkg::UCS_LOCK_EDGES,
   parameter int unsigned POR_CYC    = ucs_pkg::UCS_POR_CYC
) (
   input  wire logic       clk,                   // System clock, 100 MHz
   input  wire logic       rst,                   // Supply power-on, async high
   input  wire logic       reference_clock_input, // Reference clock domain
   input  wire logic       external_reset_n,      // Reset pin, async to clk
   input  wire logic       clock_output_strap_in, // Strap pin level
   input  wire logic       stp,                   // Link STP
   input  wire logic       uart_mode,             // UART mode active
   input  wire logic [1:0] uart_regulator_voltage_select, // Register field value
   input  wire logic       uart_sel_we,           // Field write strobe
   output logic            clock_output_strap_out, // Generated ULPI clock
   output logic            clock_output_strap_oe,  // Drive enable for clock pin
   output logic            dir,                   // ULPI DIR
   output logic [7:0]      data_out,              // ULPI data drive
   output logic            data_oe,               // ULPI data enable
   output logic            pll_locked,            // Lock status
   output logic            in_reset,              // Internal reset held
   output ucs_pkg::ucs_clk_mode_t clk_mode,       // Captured clock mode
   output logic [1:0]      regulator_sel,         // Applied regulator select
   output logic            ulpi_ready             // ULPI operation begun
);
   import ucs_pkg::*;

   // Three-stage synchronisers for pins; a level counts only once stages
   // two and three agree, so one metastable sample never reaches the logic
   localparam int unsigned N_PINS = 3;
   logic [N_PINS-1:0] pin_raw;
   logic [N_PINS-1:0] pin_q;
   assign pin_raw = {stp, clock_output_strap_in, external_reset_n};

   for (genvar i = 0; i < N_PINS; i++) begin : g_pin_sync
      logic [2:0] sync_r;
      logic       q_r;
      always_ff @(posedge clk or posedge rst) begin
         if (rst) begin
            sync_r <= 3'h0;
            q_r    <= 1'b0;
         end else begin
            sync_r <= {sync_r[1:0], pin_raw[i]};
            if (sync_r[2] == sync_r[1]) begin
               q_r <= sync_r[2];
            end
         end
      end
      assign pin_q[i] = q_r;
   end

   logic rstn_q;
   logic strap_q;
   logic stp_q;
   assign rstn_q  = pin_q[0];
   assign strap_q = pin_q[1];
   assign stp_q   = pin_q[2];

   // Power-on pulse after supply stable
   logic [7:0] por_cnt_r;
   logic       por_done_r;
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         por_cnt_r  <= 8'h00;
         por_done_r <= 1'b0;
      end else if (!por_done_r) begin
         por_cnt_r <= por_cnt_r + 8'h01;
         if (por_cnt_r == 8'(POR_CYC - 1)) begin
            por_done_r <= 1'b1;
         end
      end
   end

   // Pin low long enough counts as reset; short glitches ignored
   logic [7:0] low_cnt_r;
   logic       pin_rst_r;
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         low_cnt_r <= 8'h00;
         pin_rst_r <= 1'b1;
      end else if (!rstn_q) begin
         if (low_cnt_r != 8'(UCS_RST_MIN_CYC)) begin
            low_cnt_r <= low_cnt_r + 8'h01;
         end else begin
            pin_rst_r <= 1'b1;
         end
      end else begin
         low_cnt_r <= 8'h00;
         if (por_done_r) begin
            pin_rst_r <= 1'b0;
         end
      end
   end

   logic core_rst;
   assign core_rst = pin_rst_r | !por_done_r;
   assign in_reset = core_rst;

   // Strap capture right after reset release
   logic strap_taken_r;
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         strap_taken_r <= 1'b0;
         clk_mode      <= UCS_PHY_SOURCED;
      end else if (core_rst) begin
         strap_taken_r <= 1'b0;
      end else if (!strap_taken_r) begin
         strap_taken_r <= 1'b1;
         clk_mode <= strap_q ? UCS_LINK_SOURCED : UCS_PHY_SOURCED;
      end
   end

   // Reference-domain run level; reset held until pin and POR clear
   logic [1:0] ref_run_sync_r;
   logic       ref_run_req;
   logic       ref_alive_r;
   // Run drops while the reference is seen dead, so the first edges of a
   // restarted reference clear the stale lock before counting again
   assign ref_run_req = strap_taken_r & !core_rst & ref_alive_r;
   always_ff @(posedge reference_clock_input or posedge rst) begin
      if (rst) begin
         ref_run_sync_r <= 2'h0;
      end else begin
         ref_run_sync_r <= {ref_run_sync_r[0], ref_run_req};
      end
   end

   // Lock model: count rising reference edges from run; delayed start
   // of reference simply delays lock by the same amount
   logic [7:0] lock_cnt_r;
   logic       ref_lock_r;
   always_ff @(posedge reference_clock_input or posedge rst) begin
      if (rst) begin
         lock_cnt_r <= 8'h00;
         ref_lock_r <= 1'b0;
      end else if (!ref_run_sync_r[1]) begin
         lock_cnt_r <= 8'h00;
         ref_lock_r <= 1'b0;
      end else if (lock_cnt_r != 8'(LOCK_EDGES)) begin
         lock_cnt_r <= lock_cnt_r + 8'h01;
      end else begin
         ref_lock_r <= 1'b1;
      end
   end

   // Reference activity: toggle crosses into clk; stopped clock
   // cannot clear its own flag, so clk side times out
   logic ref_tgl_r;
   always_ff @(posedge reference_clock_input or posedge rst) begin
      if (rst) begin
         ref_tgl_r <= 1'b0;
      end else begin
         ref_tgl_r <= ~ref_tgl_r;
      end
   end

   logic [2:0] tgl_sync_r;
   logic [2:0] lock_sync_r;
   logic [5:0] idle_cnt_r;
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         tgl_sync_r  <= 3'h0;
         lock_sync_r <= 3'h0;
         idle_cnt_r  <= 6'h00;
         ref_alive_r <= 1'b0;
      end else begin
         tgl_sync_r  <= {tgl_sync_r[1:0], ref_tgl_r};
         lock_sync_r <= {lock_sync_r[1:0], ref_lock_r};
         if (tgl_sync_r[2] != tgl_sync_r[1]) begin
            idle_cnt_r  <= 6'h00;
            ref_alive_r <= 1'b1;
         end else if (idle_cnt_r != 6'(UCS_LOSS_CYC)) begin
            idle_cnt_r <= idle_cnt_r + 6'h01;
         end else begin
            ref_alive_r <= 1'b0;
         end
      end
   end

   // Lock seen across a reset or a reference stop is stale until the
   // reference side has been seen to drop it; otherwise a restart would
   // skip the relock wait
   logic lock_stale_r;
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         lock_stale_r <= 1'b1;
      end else if (core_rst || !ref_alive_r) begin
         lock_stale_r <= 1'b1;
      end else if (!lock_sync_r[2]) begin
         lock_stale_r <= 1'b0;
      end
   end

   assign pll_locked = lock_sync_r[2] & ref_alive_r & !core_rst & !lock_stale_r;

   // Output clock: divided from clk, full rate only while locked;
   // after loss it runs at the slowest divider as the PLL floor
   logic [3:0] div_cnt_r;
   logic       clk_out_r;
   logic [3:0] div_lim;
   assign div_lim = pll_locked ? 4'(UCS_DIV_HALF - 1) : 4'hf;
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         div_cnt_r <= 4'h0;
         clk_out_r <= 1'b0;
      end else if (div_cnt_r >= div_lim) begin
         div_cnt_r <= 4'h0;
         clk_out_r <= ~clk_out_r;
      end else begin
         div_cnt_r <= div_cnt_r + 4'h1;
      end
   end

   // Pin driven only in device-sourced mode once lock seen; the
   // strap must be sampled undriven first
   logic clk_started_r;
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         clk_started_r <= 1'b0;
      end else if (core_rst || clk_mode != UCS_PHY_SOURCED || !strap_taken_r) begin
         clk_started_r <= 1'b0;
      end else if (pll_locked) begin
         clk_started_r <= 1'b1;
      end
   end
   assign clock_output_strap_out = clk_started_r & clk_out_r;
   assign clock_output_strap_oe  = clk_started_r;

   // Start-up sequence: DIR held through reset, lock wait and STP high,
   // released once per reset in either mode
   typedef enum logic [1:0] {
      UCS_ST_HOLD,
      UCS_ST_WAIT,
      UCS_ST_RUN
   } ucs_start_t;

   ucs_start_t st_r;
   ucs_start_t st_nxt;

   always_comb begin
      st_nxt = st_r;
      case (st_r)
         UCS_ST_HOLD: begin
            if (!core_rst) begin
               st_nxt = UCS_ST_WAIT;
            end
         end
         UCS_ST_WAIT: begin
            if (core_rst) begin
               st_nxt = UCS_ST_HOLD;
            end else if (pll_locked && !stp_q) begin
               st_nxt = UCS_ST_RUN;
            end
         end
         UCS_ST_RUN: begin
            if (core_rst) begin
               st_nxt = UCS_ST_HOLD;
            end
         end
         default: begin
            st_nxt = UCS_ST_HOLD;
         end
      endcase
   end

   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         st_r <= UCS_ST_HOLD;
      end else begin
         st_r <= st_nxt;
      end
   end

   // Outputs follow the next state so DIR, ready and bus release
   // all change on the same edge
   logic dir_r;
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         dir_r <= 1'b1;
      end else begin
         dir_r <= (st_nxt != UCS_ST_RUN);
      end
   end

   logic ready_r;
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         ready_r <= 1'b0;
      end else begin
         ready_r <= (st_nxt == UCS_ST_RUN);
      end
   end
   assign dir        = dir_r;
   assign ulpi_ready = ready_r;

   // Idle on the bus only in the wait state, for lock and STP low; released together
   // with DIR so the link can take the bus on the following cycle
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         data_out <= UCS_ULPI_IDLE;
      end else begin
         data_out <= UCS_ULPI_IDLE;
      end
   end

   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         data_oe <= 1'b0;
      end else begin
         data_oe <= (st_nxt == UCS_ST_WAIT);
      end
   end

   // Regulator select: field resets to default, applied in UART mode
   logic [1:0] reg_field_r;
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         reg_field_r <= UCS_REG_SEL_RST;
      end else if (core_rst) begin
         reg_field_r <= UCS_REG_SEL_RST;
      end else if (uart_sel_we) begin
         reg_field_r <= uart_regulator_voltage_select;
      end
   end

   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         regulator_sel <= UCS_REG_SEL_RST;
      end else begin
         regulator_sel <= uart_mode ? reg_field_r : UCS_REG_SEL_RST;
      end
   end
endmodule

// ### inc/ucs_pkg.sv
package ucs_pkg;
   // Clock sourcing selected by the start-up strap
   typedef enum logic {
      UCS_LINK_SOURCED,
      UCS_PHY_SOURCED
   } ucs_clk_mode_t;

   localparam int unsigned UCS_SYS_CLK_MHZ      = 100;
   localparam int unsigned UCS_RST_MIN_US       = 1;
   // Least time rounds up
   localparam int unsigned UCS_RST_MIN_CYC      = UCS_RST_MIN_US * UCS_SYS_CLK_MHZ;
   localparam int unsigned UCS_POR_CYC          = 16;
   localparam int unsigned UCS_LOCK_EDGES       = 64;
   localparam int unsigned UCS_LOSS_CYC         = 32;
   localparam int unsigned UCS_DIV_HALF         = 2;
   localparam logic [7:0]  UCS_ULPI_IDLE        = 8'h00;
   localparam logic [1:0]  UCS_REG_SEL_RST      = 2'h0;
endpackage

// ### tb/ucs_link_model.sv
`timescale 1ns/1ps
module ucs_link_model (
   input  wire logic ref_en,                // Run reference clock
   input  wire logic rst_req_n,             // Wanted reset level
   input  wire logic stp_req,               // Wanted STP level
   output logic      reference_clock_input, // Link clock
   output logic      external_reset_n,      // Reset pin
   output logic      stp                    // Link STP
);
   initial reference_clock_input = 1'b0;
   // Parks low while stopped; 32 ns half period, not a multiple of the clk period
   always #32 begin
      if (ref_en) begin
         reference_clock_input = ~reference_clock_input;
      end else begin
         reference_clock_input = 1'b0;
      end
   end
   assign external_reset_n = rst_req_n;
   assign stp = stp_req;
endmodule

// ### tb/ucs_checker.sv
`timescale 1ns/1ps
module ucs_checker
   import ucs_pkg::*;
#(
   parameter int unsigned LOCK_EDGES = UCS_LOCK_EDGES,
   parameter int unsigned POR_CYC    = UCS_POR_CYC
) (
   input wire logic          clk,                           // Clock
   input wire logic          rst,                           // Reset
   input wire logic          stp,                           // STP
   input wire logic          clock_output_strap_in,         // Strap
   input wire logic          uart_mode,                     // UART
   input wire logic [1:0]    uart_regulator_voltage_select, // Field
   input wire logic          uart_sel_we,                   // Strobe
   input wire logic          clock_output_strap_oe,         // Clock oe
   input wire logic          dir,                           // DIR
   input wire logic [7:0]    data_out,                      // Data
   input wire logic          data_oe,                       // Data oe
   input wire logic          pll_locked,                    // Lock
   input wire logic          in_reset,                      // Reset held
   input wire ucs_clk_mode_t clk_mode,                      // Mode
   input wire logic [1:0]    regulator_sel,                 // Applied
   input wire logic          ulpi_ready                     // Ready
);
   default clocking cb @(posedge clk); endclocking
   default disable iff (rst);
   // Six samples outlast the STP synchroniser and its agreement stage
   sequence s_stp_held; stp [*6]; endsequence
   sequence s_running; !in_reset [*3]; endsequence
   AST_DIR_RST: assert property ($rose(in_reset) |-> ##[0:2] dir)
      else $error("dir low in reset");
   AST_DIR_LOCK: assert property ($fell(dir) |-> $past(pll_locked))
      else $error("dir fell before lock");
   AST_DIR_STP: assert property (s_stp_held |-> !$fell(dir))
      else $error("dir fell while stp high");
   AST_READY: assert property ($rose(ulpi_ready) |-> !dir && !data_oe)
      else $error("ready with bus held");
   AST_IDLE: assert property (data_oe |-> dir && data_out == UCS_ULPI_IDLE)
      else $error("bus not idle");
   AST_MODE: assert property ($fell(in_reset) |-> ##2
      clk_mode == (clock_output_strap_in ? UCS_LINK_SOURCED : UCS_PHY_SOURCED))
      else $error("mode not from strap");
   AST_HOLD: assert property (s_running |-> $stable(clk_mode))
      else $error("mode changed");
   AST_OE: assert property ($rose(clock_output_strap_oe) |->
      $past(pll_locked) && clk_mode == UCS_PHY_SOURCED)
      else $error("clock driven wrongly");
   AST_REG: assert property (uart_sel_we && uart_mode && !in_reset |->
      ##2 regulator_sel == $past(uart_regulator_voltage_select, 2))
      else $error("regulator select wrong");
endmodule
bind ucs_clock_reset_startup ucs_checker #(
   .LOCK_EDGES(LOCK_EDGES),
   .POR_CYC(POR_CYC)
) u_chk (.clk, .rst, .stp, .clock_output_strap_in, .uart_mode,
   .uart_regulator_voltage_select, .uart_sel_we, .clock_output_strap_oe,
   .dir, .data_out, .data_oe, .pll_locked, .in_reset, .clk_mode,
   .regulator_sel, .ulpi_ready);

// ### tb/test_ulpi_phy_clock_reset_startup.sv
`timescale 1ns/1ps
module test_ulpi_phy_clock_reset_startup;
   import ucs_pkg::*;
   logic clk, rst, ref_en, pin_n, stp_req, strap, uart_mode, we;
   logic [1:0] sel, regulator_sel;
   logic reference_clock_input, external_reset_n, stp, ck_out, oe;
   logic dir, data_oe, pll_locked, in_reset, ulpi_ready;
   logic [7:0] data_out;
   ucs_clk_mode_t clk_mode;
   int n_errors = 0;
   int n_tests = 0;
   ucs_link_model u_link (.ref_en, .rst_req_n(pin_n), .stp_req,
      .reference_clock_input, .external_reset_n, .stp);
   // Short counts keep lock and power-on waits brief
   ucs_clock_reset_startup #(.LOCK_EDGES(8), .POR_CYC(4)) u_dut (.clk, .rst,
      .reference_clock_input, .external_reset_n, .clock_output_strap_in(strap),
      .stp, .uart_mode, .uart_regulator_voltage_select(sel), .uart_sel_we(we),
      .clock_output_strap_out(ck_out), .clock_output_strap_oe(oe), .dir,
      .data_out, .data_oe, .pll_locked, .in_reset, .clk_mode, .regulator_sel,
      .ulpi_ready);
   always #5 clk = ~clk;
   task automatic check(string name, logic [7:0] seen, logic [7:0] exp);
      n_tests++;
      if (seen !== exp) begin
         n_errors++;
         $display("wrong value %s expected %h seen %h", name, exp, seen);
      end
   endtask
   task automatic cyc(int n);
      repeat (n) @(negedge clk);
   endtask
   task automatic wait_for(logic on_ready);
      for (int i = 0; i < 1000; i++) begin
         if ((on_ready ? ulpi_ready : pll_locked) === 1'b1) break;
         cyc(1);
      end
   endtask
   function automatic ucs_clk_mode_t exp_mode(logic s);
      return s ? UCS_LINK_SOURCED : UCS_PHY_SOURCED;
   endfunction
   task automatic wrap_up();
      if (n_errors == 0 && n_tests > 0) $display("All tests passed");
      else $display("Some tests failed");
      $finish;
   endtask
   initial begin
      #200000;
      n_errors++;
      wrap_up();
   end
   initial begin
      clk = 0; rst = 1; ref_en = 1; pin_n = 0; stp_req = 0;
      strap = 1; uart_mode = 1; we = 0; sel = 0;
      void'($urandom(32'hccaa3076));
      cyc(16);
      rst = 0;
      cyc(200);
      check("in_reset", in_reset, 1);
      check("ulpi_ready", ulpi_ready, 0);
      stp_req = 1;
      pin_n = 1;
      wait_for(0);
      cyc(30);
      check("dir held", dir, 1);
      stp_req = 0;
      wait_for(1);
      check("dir", dir, 0);
      check("clk_mode", clk_mode, exp_mode(1));
      check("clock oe", oe, 0);
      check("bus released", data_oe, 0);
      for (int k = 0; k < 12; k++) begin
         sel = (k < 2) ? 2'(3 * k) : 2'($urandom);
         we = 1;
         cyc(1);
         we = 0;
         cyc(2);
         check("regulator_sel", regulator_sel, sel);
      end
      pin_n = 0;
      cyc(50);
      pin_n = 1;
      cyc(10);
      check("short low", ulpi_ready, 1);
      strap = 0; pin_n = 0; ref_en = 0;
      cyc(120);
      pin_n = 1;
      cyc(150);
      check("late dir", dir, 1);
      check("late lock", pll_locked, 0);
      ref_en = 1;
      cyc(20);
      check("relock wait", pll_locked, 0);
      wait_for(1);
      check("clk_mode", clk_mode, exp_mode(0));
      check("clock oe", oe, 1);
      ref_en = 0;
      cyc(40);
      check("lock lost", pll_locked, 0);
      stp_req = 1;
      ref_en = 1;
      cyc(100);
      stp_req = 0;
      rst = 1;
      cyc(2);
      check("reg default", regulator_sel, UCS_REG_SEL_RST);
      check("dir in rst", dir, 1);
      rst = 0;
      wait_for(1);
      check("restart", ulpi_ready, 1);
      wrap_up();
   end
endmodule
